// ==== design/asrc_pkg.sv ====
// constants and types for the asynchronous static memory port controller
// ----------------------------------------------------------------------
// Overview of operation
// R1 - cs_n or oe_n high: memory floats io_bus
// R2 - read: cs_n, oe_n low, store_n high
// R3 - write while cs_n and store_n low
// R4 - oe_n falling after store_n: bus stays floated
// R5 - cs_n falling after store_n: bus floated
// R6 - cs_n rising before store_n: bus floated
// R7 - read address stable at least 15 ns
// R8 - data valid 15 ns after cs_n low
// R9 - data valid 6 ns after oe_n low
// R10 - old data held 5 ns after address change
// R11 - drive no sooner 5 ns, release 6 ns
// R12 - oe_n: drive from 0 ns, float 6 ns
// R13 - address setup 0/12 ns, store_n 12, cycle 15
// R14 - write data 7 ns before end, hold 0
// R15 - store_n falling releases bus within 6 ns
// R16 - no drive 5 ns after store_n rises
// R17 - cs_n write: cs_n low 10 ns, hold 0
// R18 - turn-off faster than turn-on, no contention
// R19 - 262,144 words of 4 bits, 18 addresses
// R20 - round minima up, sample after maximum access
// ----------------------------------------------------------------------
package asrc_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 4;
	localparam int CLK_PS = 4000;
	// times in picoseconds, as printed in ns
	localparam int T_ADDR_TO_VALID_PS = 15000;
	localparam int T_SELECT_TO_VALID_PS = 15000;
	localparam int T_OE_TO_VALID_PS = 6000;
	localparam int T_CYCLE_PS = 15000;
	localparam int T_STORE_LOW_PS = 12000;
	localparam int T_ADDR_TO_END_PS = 12000;
	localparam int T_DATA_TO_END_PS = 7000;
	localparam int T_FLOAT_PS = 6000;
	localparam int T_TURN_ON_PS = 5000;
	// least times round up, never under one cycle
	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RD_ACCESS_CYC = cyc_up(T_ADDR_TO_VALID_PS > T_SELECT_TO_VALID_PS ?
		T_ADDR_TO_VALID_PS : T_SELECT_TO_VALID_PS);
	localparam int WR_PULSE_CYC = cyc_up(T_STORE_LOW_PS > T_ADDR_TO_END_PS ?
		T_STORE_LOW_PS : T_ADDR_TO_END_PS);
	localparam int WR_DATA_CYC = cyc_up(T_DATA_TO_END_PS);
	localparam int CYCLE_CYC = cyc_up(T_CYCLE_PS);
	localparam int FLOAT_CYC = cyc_up(T_FLOAT_PS);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] RD_ACCESS_N = CNT_W'(RD_ACCESS_CYC);
	localparam logic [CNT_W-1:0] WR_PULSE_N = CNT_W'(WR_PULSE_CYC);
	localparam logic [CNT_W-1:0] CYCLE_N = CNT_W'(CYCLE_CYC);
	localparam logic [CNT_W-1:0] FLOAT_N = CNT_W'(FLOAT_CYC);
	typedef enum logic [2:0] {
		ASRC_IDLE = 3'h0,
		ASRC_RD = 3'h1,
		ASRC_WR = 3'h2,
		ASRC_RECOVER = 3'h3
	} asrc_state_t;
endpackage

// ==== design/asrc_timer.sv ====
// down-counter that times each phase of a memory cycle
`timescale 1ns/100ps
module asrc_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// load and status
	input wire logic load,
	input wire logic [asrc_pkg::CNT_W-1:0] load_val,
	output logic done
);
	logic [asrc_pkg::CNT_W-1:0] cnt_q, cnt_d;

	// a load wins over counting so back-to-back phases never lose a cycle
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != asrc_pkg::CNT_ZERO) begin
			cnt_d = cnt_q - asrc_pkg::CNT_ONE;
		end
	end

	// registered count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= asrc_pkg::CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// done in the last counted cycle
	assign done = (cnt_q == asrc_pkg::CNT_ONE);
endmodule

// ==== design/asrc_ctrl.sv ====
// controller that drives an asynchronous 256K x 4 static memory
`timescale 1ns/100ps
module asrc_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	// user read answer
	output logic rsp_valid,
	output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
	// memory pins
	output logic [asrc_pkg::ADDR_W-1:0] addr_lines,
	output logic cs_n,
	output logic oe_n,
	output logic store_n,
	input wire logic [asrc_pkg::DATA_W-1:0] io_bus_i,
	output logic [asrc_pkg::DATA_W-1:0] io_bus_o,
	output logic io_bus_oe_n
);
	asrc_pkg::asrc_state_t state_q, state_d;
	logic [asrc_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [asrc_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic cs_n_q, cs_n_d, oe_n_q, oe_n_d, st_n_q, st_n_d, drv_n_q, drv_n_d;
	logic rsp_q, rsp_d;
	logic load;
	logic [asrc_pkg::CNT_W-1:0] load_val;
	logic done;

	// ----------------------------------------------------------------
	// phase timer
	// ----------------------------------------------------------------
	asrc_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(load),
		.load_val(load_val),
		.done(done)
	);

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	// reads hold address and strobes for the full access time; writes are
	// store_n controlled with oe_n held high so the memory never drives
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		cs_n_d = cs_n_q;
		oe_n_d = oe_n_q;
		st_n_d = st_n_q;
		drv_n_d = drv_n_q;
		rsp_d = 1'b0;
		load = 1'b0;
		load_val = asrc_pkg::CNT_ZERO;
		unique case (state_q)
			asrc_pkg::ASRC_IDLE: begin
				if (req_valid) begin
					addr_d = req_addr; // R19
					cs_n_d = 1'b0;
					load = 1'b1;
					if (req_write) begin
						// address set up before store_n falls, 0 ns is enough
						wdata_d = req_wdata;
						st_n_d = 1'b0; // R3 R13
						oe_n_d = 1'b1; // R4
						drv_n_d = 1'b0; // R14
						load_val = asrc_pkg::WR_PULSE_N; // R13
						state_d = asrc_pkg::ASRC_WR;
					end else begin
						oe_n_d = 1'b0; // R2
						st_n_d = 1'b1;
						load_val = asrc_pkg::RD_ACCESS_N; // R7 R8 R9 R20
						state_d = asrc_pkg::ASRC_RD;
					end
				end
			end
			asrc_pkg::ASRC_RD: begin
				if (done) begin
					// sample only after the slowest access delay has passed
					rdata_d = io_bus_i; // R20 R10
					rsp_d = 1'b1;
					cs_n_d = 1'b1;
					oe_n_d = 1'b1; // R1
					load = 1'b1;
					load_val = asrc_pkg::FLOAT_N; // R11 R12
					state_d = asrc_pkg::ASRC_RECOVER;
				end
			end
			asrc_pkg::ASRC_WR: begin
				if (done) begin
					// store_n and cs_n rise together; data held one more cycle
					st_n_d = 1'b1; // R14 R17
					cs_n_d = 1'b1;
					load = 1'b1;
					load_val = asrc_pkg::FLOAT_N; // R16
					state_d = asrc_pkg::ASRC_RECOVER;
				end
			end
			asrc_pkg::ASRC_RECOVER: begin
				// memory turn-off is done before anyone drives again
				drv_n_d = 1'b1; // R18 R15
				if (done) begin
					state_d = asrc_pkg::ASRC_IDLE;
				end
			end
			default: begin
				state_d = asrc_pkg::ASRC_IDLE;
			end
		endcase
	end

	// sequencer registers; strobes idle high so the memory is deselected
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= asrc_pkg::ASRC_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			cs_n_q <= 1'b1; // R1
			oe_n_q <= 1'b1;
			st_n_q <= 1'b1;
			drv_n_q <= 1'b1;
			rsp_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			cs_n_q <= cs_n_d;
			oe_n_q <= oe_n_d;
			st_n_q <= st_n_d;
			drv_n_q <= drv_n_d;
			rsp_q <= rsp_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// WR_PULSE covers the 15 ns cycle too since setup is 0 and recovery adds
	assign req_ready = (state_q == asrc_pkg::ASRC_IDLE);
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
	assign addr_lines = addr_q;
	assign cs_n = cs_n_q;
	assign oe_n = oe_n_q;
	assign store_n = st_n_q;
	assign io_bus_o = wdata_q;
	assign io_bus_oe_n = drv_n_q;
endmodule

// ==== test/asrc_chk.sv ====
// assertion checker for the static memory port controller
`timescale 1ns/100ps
module asrc_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user side
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
	// memory pins
	input wire logic [asrc_pkg::ADDR_W-1:0] addr_lines,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic store_n,
	input wire logic [asrc_pkg::DATA_W-1:0] io_bus_i,
	input wire logic [asrc_pkg::DATA_W-1:0] io_bus_o,
	input wire logic io_bus_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = req_valid && req_ready;
	// ----------------------------------------
	// read and write pin phases
	// ----------------------------------------
	sequence rd_seq;
		(!cs_n && !oe_n && store_n) [*4] ##1 (cs_n && oe_n && rsp_valid);
	endsequence
	sequence wr_seq;
		(!cs_n && !store_n && oe_n && !io_bus_oe_n) [*3] ##1
			(cs_n && store_n && !io_bus_oe_n) ##1 io_bus_oe_n;
	endsequence
	rd_cycle_a: assert property (take && !req_write |=> rd_seq)
		else $error("read pin phase wrong");
	wr_cycle_a: assert property (take && req_write |=> wr_seq)
		else $error("write pin phase wrong");
	addr_out_a: assert property (take |=> addr_lines == $past(req_addr))
		else $error("address not presented");
	addr_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable(addr_lines))
		else $error("address moved while selected");
	wr_data_a: assert property (take && req_write |=> io_bus_o == $past(req_wdata))
		else $error("write data wrong");
	rd_data_a: assert property (rsp_valid |-> rsp_rdata == $past(io_bus_i))
		else $error("read data not sampled");
	oe_in_wr_a: assert property (!store_n |-> oe_n)
		else $error("output enable during write");
	no_fight_a: assert property (!io_bus_oe_n |-> oe_n)
		else $error("both ends drive data");
	// a read spends four access and two float cycles, a write three pulse and two
	cycle_len_a: assert property (take && !req_write |=> !req_ready [*6] ##1 req_ready)
		else $error("read cycle length wrong");
	wr_len_a: assert property (take && req_write |=> !req_ready [*5] ##1 req_ready)
		else $error("write cycle length wrong");
endmodule

// ==== test/asrc_mem.sv ====
// behavioural model of the 256K x 4 static memory
`timescale 1ns/100ps
module asrc_mem (
	// pins from the controller
	input wire logic [17:0] addr_lines,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic store_n,
	input wire logic [3:0] din,
	output logic [3:0] q
);
	logic [3:0] mem [int];
	logic [3:0] lst = 4'h0;
	logic wr_q = 1'b0;
	wire wr = !cs_n && !store_n;
	// data turns valid only after the access time, so an early sample sees the inverse of the last word
	wire rd_on = !cs_n && !oe_n && store_n;
	wire #15 rd_ok = rd_on;
	// capture at the end of the overlap only, a glitchy start never stores
	always @(wr) begin
		if (wr_q === 1'b1) mem[addr_lines] = din;
		wr_q = wr;
	end
	// unwritten words read a pattern; a floated bus shows the inverse of the last word
	always @* begin
		if (rd_on && rd_ok) begin
			q = mem.exists(addr_lines) ? mem[addr_lines] : addr_lines[3:0] ^ addr_lines[17:14];
			lst = q;
		end else q = ~lst;
	end
endmodule

// ==== test/asrc_ctrl_tb.sv ====
// self-checking bench for the static memory port controller
`timescale 1ns/100ps
module asrc_ctrl_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [17:0] req_addr = 18'h0;
	logic [3:0] req_wdata = 4'h0;
	logic req_ready, rsp_valid, cs_n, oe_n, store_n, io_bus_oe_n;
	logic [3:0] rsp_rdata, io_bus_o, mem_q, io_bus_i;
	logic [17:0] addr_lines;
	logic [3:0] shadow [int];
	logic [31:0] seed = 32'h4A65;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	// wire level: whoever enables wins, the model floats during writes
	assign io_bus_i = io_bus_oe_n ? mem_q : io_bus_o;
	asrc_ctrl u_dut (.*);
	asrc_mem u_mem (.addr_lines(addr_lines), .cs_n(cs_n), .oe_n(oe_n), .store_n(store_n),
		.din(io_bus_i), .q(mem_q));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [3:0] want(input logic [17:0] a);
		return shadow.exists(a) ? shadow[a] : a[3:0] ^ a[17:14];
	endfunction
	task automatic op(input logic w, input logic [17:0] a, input logic [3:0] d);
		int i;
		for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		@(negedge clk);
		if (w) shadow[a] = d;
		else begin
			for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
			tests_run++;
			if (rsp_valid !== 1'b1) begin
				fail_count++;
				$display("unexpected rsp_valid at %h: expected 1 seen %b", a, rsp_valid);
			end
			tests_run++;
			if (rsp_rdata !== want(a)) begin
				fail_count++;
				$display("unexpected rsp_rdata at %h: expected %h seen %h", a, want(a), rsp_rdata);
			end
		end
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// a hang costs a mismatch and ends the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		int k;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		op(1'b1, 18'h00000, 4'hA);
		op(1'b1, 18'h3FFFF, 4'h5);
		op(1'b0, 18'h00000, 4'h0);
		op(1'b0, 18'h3FFFF, 4'h0);
		op(1'b0, 18'h12345, 4'h0);
		// small address set so random writes are read back often
		for (k = 0; k < 60; k++) begin
			seed = xs(seed);
			op(seed[4], {seed[20:19], 12'h0, seed[3:0]}, seed[11:8]);
		end
		end_sim();
	end
endmodule
bind asrc_ctrl asrc_chk u_chk (.*);
